/* File: rtl/rdqp_addr_form.v */
// forms one physical queue byte address from a word-index field and the queue base
`timescale 1ns/100ps
`default_nettype none
`include "rdqp_map.vh"

module rdqp_addr_form (
   input  wire        clock_in,
   input  wire        resetn_in,
   input  wire [15:0] field_in,
   input  wire [31:0] base_in,
   output reg  [31:0] addr_out
);

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         addr_out <= `RDQP_ADDR_RESET;
      end else begin
         // field shifted two left plus base
         addr_out <= base_in + {{`RDQP_ADDR_PAD_WIDTH{1'h0}}, field_in, 2'h0};
      end
   end

endmodule
`default_nettype wire

/* File: rtl/rdqp_map.vh */
// register map and field constants for the receive descriptor queue pointers
`ifndef RDQP_MAP_VH
`define RDQP_MAP_VH

`define RDQP_ADDR_WIDTH           12
`define RDQP_FIELD_WIDTH          16
`define RDQP_FIELD_MSB            15
`define RDQP_WORD_SHIFT           2
`define RDQP_ADDR_PAD_WIDTH       14

`define RDQP_SMALL_FREE_READ_OFS  12'h2b0
`define RDQP_SMALL_FREE_END_OFS   12'h2b4
`define RDQP_READY_START_OFS      12'h2b8
`define RDQP_READY_WRITE_OFS      12'h2bc

`define RDQP_FIELD_RESET          16'h0000
`define RDQP_UPPER_READ           16'h0000
`define RDQP_ADDR_RESET           32'h00000000
`define RDQP_UNMAPPED_READ        32'h00000000

`define RDQP_SEL_NONE             3'h0
`define RDQP_SEL_SMALL_FREE_READ  3'h1
`define RDQP_SEL_SMALL_FREE_END   3'h2
`define RDQP_SEL_READY_START      3'h3
`define RDQP_SEL_READY_WRITE      3'h4

`endif

/* File: rtl/rdqp_regs.v */
// receive descriptor reference queue pointer registers and their physical addresses
//
// What this block does
// - Holds a 16-bit small free queue read pointer standing for pointer bits 17 to 2.
// - Holds a 16-bit small free queue end field standing for end address bits 17 to 2.
// - Holds a 16-bit ready queue start field standing for start address bits 17 to 2.
// - Holds a 16-bit ready queue write pointer standing for pointer bits 17 to 2.
// - Each physical address is the field shifted left by two plus the 32-bit queue base.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "rdqp_map.vh"

module rdqp_regs (
   input  wire        clock_in,
   input  wire        resetn_in,
   input  wire [11:0] reg_addr_in,
   input  wire [31:0] reg_wdata_in,
   input  wire        reg_write_in,
   input  wire        reg_read_in,
   input  wire [31:0] receive_queue_base_in,
   input  wire        small_free_queue_read_ptr_load_in,
   input  wire [15:0] small_free_queue_read_ptr_value_in,
   input  wire        ready_queue_write_ptr_load_in,
   input  wire [15:0] ready_queue_write_ptr_value_in,
   output reg  [31:0] reg_rdata_out,
   output wire [15:0] small_free_queue_read_ptr_out,
   output wire [15:0] small_free_queue_end_addr_out,
   output wire [15:0] ready_queue_start_addr_out,
   output wire [15:0] ready_queue_write_ptr_out,
   output wire [31:0] small_free_queue_read_phys_out,
   output wire [31:0] small_free_queue_end_phys_out,
   output wire [31:0] ready_queue_start_phys_out,
   output wire [31:0] ready_queue_write_phys_out
);

   reg [15:0] small_free_queue_read_ptr;
   reg [15:0] small_free_queue_end_addr;
   reg [15:0] ready_queue_start_addr;
   reg [15:0] ready_queue_write_ptr;

   reg [15:0] next_small_free_queue_read_ptr;
   reg [15:0] next_small_free_queue_end_addr;
   reg [15:0] next_ready_queue_start_addr;
   reg [15:0] next_ready_queue_write_ptr;
   reg [31:0] next_reg_rdata;

   wire [2:0] write_sel;
   wire [2:0] read_sel;

   // maps a byte address onto a register select, none for unmapped
   function [2:0] reg_select;
      input [11:0] addr;
      begin
         case (addr)
            `RDQP_SMALL_FREE_READ_OFS: reg_select = `RDQP_SEL_SMALL_FREE_READ;
            `RDQP_SMALL_FREE_END_OFS:  reg_select = `RDQP_SEL_SMALL_FREE_END;
            `RDQP_READY_START_OFS:     reg_select = `RDQP_SEL_READY_START;
            `RDQP_READY_WRITE_OFS:     reg_select = `RDQP_SEL_READY_WRITE;
            default:                   reg_select = `RDQP_SEL_NONE;
         endcase
      end
   endfunction

   // places a field in the low half with the unused upper half at zero
   function [31:0] read_word;
      input [15:0] field;
      begin
         read_word = {`RDQP_UPPER_READ, field};
      end
   endfunction

   assign write_sel = reg_write_in ? reg_select(reg_addr_in) : `RDQP_SEL_NONE;
   assign read_sel  = reg_read_in  ? reg_select(reg_addr_in) : `RDQP_SEL_NONE;

   // software writes, then dma engine loads on top of them
   always @* begin
      next_small_free_queue_read_ptr = small_free_queue_read_ptr;
      next_small_free_queue_end_addr = small_free_queue_end_addr;
      next_ready_queue_start_addr    = ready_queue_start_addr;
      next_ready_queue_write_ptr     = ready_queue_write_ptr;
      // low sixteen bits written, upper ignored
      case (write_sel)
         `RDQP_SEL_SMALL_FREE_READ: begin
            next_small_free_queue_read_ptr = reg_wdata_in[`RDQP_FIELD_MSB:0];
         end
         `RDQP_SEL_SMALL_FREE_END: begin
            next_small_free_queue_end_addr = reg_wdata_in[`RDQP_FIELD_MSB:0];
         end
         `RDQP_SEL_READY_START: begin
            next_ready_queue_start_addr = reg_wdata_in[`RDQP_FIELD_MSB:0];
         end
         `RDQP_SEL_READY_WRITE: begin
            next_ready_queue_write_ptr = reg_wdata_in[`RDQP_FIELD_MSB:0];
         end
         default: begin
            next_small_free_queue_read_ptr = small_free_queue_read_ptr;
         end
      endcase
      // read pointer advanced by the dma engine
      if (small_free_queue_read_ptr_load_in) begin
         next_small_free_queue_read_ptr = small_free_queue_read_ptr_value_in;
      end
      // write pointer advanced by the dma engine
      if (ready_queue_write_ptr_load_in) begin
         next_ready_queue_write_ptr = ready_queue_write_ptr_value_in;
      end
   end

   // read data stand only in the cycle after the strobe
   always @* begin
      case (read_sel)
         `RDQP_SEL_SMALL_FREE_READ: next_reg_rdata = read_word(small_free_queue_read_ptr);
         `RDQP_SEL_SMALL_FREE_END:  next_reg_rdata = read_word(small_free_queue_end_addr);
         `RDQP_SEL_READY_START:     next_reg_rdata = read_word(ready_queue_start_addr);
         `RDQP_SEL_READY_WRITE:     next_reg_rdata = read_word(ready_queue_write_ptr);
         default:                   next_reg_rdata = `RDQP_UNMAPPED_READ;
      endcase
   end

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         small_free_queue_read_ptr <= `RDQP_FIELD_RESET;
      end else begin
         small_free_queue_read_ptr <= next_small_free_queue_read_ptr;
      end
   end

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         small_free_queue_end_addr <= `RDQP_FIELD_RESET;
      end else begin
         small_free_queue_end_addr <= next_small_free_queue_end_addr;
      end
   end

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         ready_queue_start_addr <= `RDQP_FIELD_RESET;
      end else begin
         ready_queue_start_addr <= next_ready_queue_start_addr;
      end
   end

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         ready_queue_write_ptr <= `RDQP_FIELD_RESET;
      end else begin
         ready_queue_write_ptr <= next_ready_queue_write_ptr;
      end
   end

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= `RDQP_UNMAPPED_READ;
      end else begin
         reg_rdata_out <= next_reg_rdata;
      end
   end

   assign small_free_queue_read_ptr_out = small_free_queue_read_ptr;
   assign small_free_queue_end_addr_out = small_free_queue_end_addr;
   assign ready_queue_start_addr_out    = ready_queue_start_addr;
   assign ready_queue_write_ptr_out     = ready_queue_write_ptr;

   // physical read address of small free queue
   rdqp_addr_form u_small_free_read (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .field_in  (small_free_queue_read_ptr),
      .base_in   (receive_queue_base_in),
      .addr_out  (small_free_queue_read_phys_out)
   );

   // physical end address of small free queue
   rdqp_addr_form u_small_free_end (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .field_in  (small_free_queue_end_addr),
      .base_in   (receive_queue_base_in),
      .addr_out  (small_free_queue_end_phys_out)
   );

   // physical start address of ready queue
   rdqp_addr_form u_ready_start (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .field_in  (ready_queue_start_addr),
      .base_in   (receive_queue_base_in),
      .addr_out  (ready_queue_start_phys_out)
   );

   // physical write address of ready queue
   rdqp_addr_form u_ready_write (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .field_in  (ready_queue_write_ptr),
      .base_in   (receive_queue_base_in),
      .addr_out  (ready_queue_write_phys_out)
   );

endmodule
`default_nettype wire

/* File: test/rdqp_checker.sv */
// port assertions for the queue pointer register block
`timescale 1ns/100ps
`default_nettype none
module rdqp_checker (
   input wire logic        clock_in,
   input wire logic        resetn_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_write_in,
   input wire logic        reg_read_in,
   input wire logic [31:0] receive_queue_base_in,
   input wire logic        ready_queue_write_ptr_load_in,
   input wire logic [15:0] ready_queue_write_ptr_value_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [15:0] small_free_queue_read_ptr_out,
   input wire logic [15:0] small_free_queue_end_addr_out,
   input wire logic [15:0] ready_queue_start_addr_out,
   input wire logic [15:0] ready_queue_write_ptr_out,
   input wire logic [31:0] small_free_queue_end_phys_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   property p_rd_sfr; reg_read_in && reg_addr_in == 12'h2b0
      |=> reg_rdata_out == {16'h0000, $past(small_free_queue_read_ptr_out)}; endproperty
   a_rd_sfr: assert property (p_rd_sfr) else $error("read pointer readback");
   property p_wr_end; reg_write_in && reg_addr_in == 12'h2b4
      |=> small_free_queue_end_addr_out == $past(reg_wdata_in[15:0]); endproperty
   a_wr_end: assert property (p_wr_end) else $error("end field write");
   property p_wr_start; reg_write_in && reg_addr_in == 12'h2b8
      |=> ready_queue_start_addr_out == $past(reg_wdata_in[15:0]); endproperty
   a_wr_start: assert property (p_wr_start) else $error("start field write");
   property p_ld_wr; ready_queue_write_ptr_load_in
      |=> ready_queue_write_ptr_out == $past(ready_queue_write_ptr_value_in); endproperty
   a_ld_wr: assert property (p_ld_wr) else $error("write pointer load");
   property p_phys; $past(resetn_in) |-> small_free_queue_end_phys_out ==
      $past(receive_queue_base_in) + {14'h0, $past(small_free_queue_end_addr_out), 2'h0};
   endproperty
   a_phys: assert property (p_phys) else $error("end physical address");
   property p_rd_idle; !reg_read_in |=> reg_rdata_out == 32'h00000000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   c_rd: cover property (reg_read_in && reg_addr_in == 12'h2b0);
   c_race: cover property (ready_queue_write_ptr_load_in && reg_write_in);
   c_wrap: cover property (small_free_queue_end_phys_out < receive_queue_base_in);
endmodule
bind rdqp_regs rdqp_checker u_chk (.*);
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the queue pointer register block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clock_in = 1'b0, resetn_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
   logic small_free_queue_read_ptr_load_in = 1'b0, ready_queue_write_ptr_load_in = 1'b0;
   logic [15:0] small_free_queue_read_ptr_value_in = 16'h0000;
   logic [15:0] ready_queue_write_ptr_value_in = 16'h0000;
   logic [11:0] reg_addr_in = 12'h000;
   logic [31:0] reg_wdata_in = 32'h00000000, receive_queue_base_in = 32'h00000000;
   logic [31:0] reg_rdata_out, small_free_queue_read_phys_out, small_free_queue_end_phys_out;
   logic [31:0] ready_queue_start_phys_out, ready_queue_write_phys_out;
   logic [15:0] small_free_queue_read_ptr_out, small_free_queue_end_addr_out;
   logic [15:0] ready_queue_start_addr_out, ready_queue_write_ptr_out;
   int n_errors = 0;
   int checked = 0;
   rdqp_regs dut (.*);
   always #25 clock_in = ~clock_in;
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      reg_write_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clock_in);
      reg_read_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      @(negedge clock_in);
      chk("reg_rdata_out", exp, reg_rdata_out);
   endtask
   function automatic logic [31:0] ph(input logic [15:0] f);
      return receive_queue_base_in + {14'h0, f, 2'h0};
   endfunction
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         rd(12'h2b0 + 12'(4 * i), 32'h00000000);
         wr(12'h2b0 + 12'(4 * i), {16'hffff, 16'h8421 << i});
         rd(12'h2b0 + 12'(4 * i), {16'h0000, 16'h8421 << i});
      end
   endtask
   task automatic t_phys;
      @(posedge clock_in);
      receive_queue_base_in <= 32'hfffffff0;
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      chk("read phys", ph(16'h8421), small_free_queue_read_phys_out);
      chk("end phys", ph(16'h0842), small_free_queue_end_phys_out);
      chk("start phys", ph(16'h1084), ready_queue_start_phys_out);
      chk("write phys", ph(16'h2108), ready_queue_write_phys_out);
      chk("read field", 32'h00008421, {16'h0000, small_free_queue_read_ptr_out});
      chk("end field", 32'h00000842, {16'h0000, small_free_queue_end_addr_out});
      chk("start field", 32'h00001084, {16'h0000, ready_queue_start_addr_out});
      chk("write field", 32'h00002108, {16'h0000, ready_queue_write_ptr_out});
   endtask
   task automatic t_unmapped;
      wr(12'h2c0, 32'h0000ffff);
      rd(12'h2c0, 32'h00000000);
      rd(12'h2b4, 32'h00000842);
   endtask
   task automatic t_load;
      @(posedge clock_in);
      reg_write_in <= 1'b1;
      reg_addr_in <= 12'h2bc;
      reg_wdata_in <= 32'h00000001;
      ready_queue_write_ptr_load_in <= 1'b1;
      ready_queue_write_ptr_value_in <= 16'hfffe;
      small_free_queue_read_ptr_load_in <= 1'b1;
      small_free_queue_read_ptr_value_in <= 16'h7ffd;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
      ready_queue_write_ptr_load_in <= 1'b0;
      small_free_queue_read_ptr_load_in <= 1'b0;
      rd(12'h2bc, 32'h0000fffe);
      rd(12'h2b0, 32'h00007ffd);
   endtask
   task automatic t_reset;
      @(posedge clock_in);
      resetn_in <= 1'b0;
      @(posedge clock_in);
      resetn_in <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(12'h2b0 + 12'(4 * i), 32'h00000000);
      end
      chk("write phys after reset", ph(16'h0000), ready_queue_write_phys_out);
   endtask
   task automatic print_verdict;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock_in);
      resetn_in <= 1'b1;
      t_regs();
      t_phys();
      t_unmapped();
      t_load();
      t_reset();
      print_verdict();
   end
   initial begin
      #20000;
      n_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
